// File: src/sdram_cfg_defs.svh
// Overview of operation
// [R1] Capture config on load command, hold until reloaded
// [R2] Span bits 0-2, order bit 3, latency 4-6
// [R3] Bits 7-8 op mode, 9 write mode, 10-11 zero
// [R4] Select bits 12-13 zero target the primary config
// [R5] Load only when idle, then wait before next
// [R6] Spans 1,2,4,8 both orders; page only sequential
// [R7] Page burst runs until stop, wraps at page end
// [R8] Span limits columns reached per command
// [R9] Upper column bits pick block, low bits start
// [R10] Burst wraps inside its block at the boundary
// [R11] Order bit picks order; page forces sequential
// [R12] Sequential: offset plus k modulo span
// [R13] Interleaved: offset XOR k
// [R14] Page burst covers whole row from start column
// [R15] Span one: full column, order bit ignored
// [R16] Controller never programs reserved span codes
// [R17] Latency one to three clocks before data valid
// [R18] Write single bit makes writes one location
// [R19] Normal mode only with bits 7,8,10,11 zero
// [R20] Span codes 0,1,2,3,7; latency equals clocks
// [R21] One new column per clock, low bits only
`ifndef SDRAM_CFG_DEFS_SVH
`define SDRAM_CFG_DEFS_SVH

`define CFG_W          14
`define SPAN_LO        0
`define SPAN_HI        2
`define ORDER_BIT      3
`define LAT_LO         4
`define LAT_HI         6
`define OP_LO          7
`define OP_HI          8
`define WR_SINGLE_BIT  9
`define RSV_LO         10
`define RSV_HI         11
`define SEL_LO         12
`define SEL_HI         13
`define SEL_PRIMARY    2'h0

`define SPAN_1         3'h0
`define SPAN_2         3'h1
`define SPAN_4         3'h2
`define SPAN_8         3'h3
`define SPAN_FULL      3'h7

`define CFG_RESET      14'h0000
`define MODE_VAL_RESET 14'h0022

`define REG_MODE_VAL   12'h000
`define REG_CMD        12'h004
`define REG_STATUS     12'h008

`define OP_LOAD        3'h1
`define OP_READ        3'h2
`define OP_WRITE       3'h3
`define OP_STOP        3'h4
`define CMD_COL_LO     16

`define ST_BUSY_BIT    0
`define ST_BURST_BIT   1
`define ST_REFUSED_BIT 2
`define ST_BADMODE_BIT 3

`define LOAD_SETTLE_CYCLES 2

`endif

// File: src/sdram_cfg_pkg.sv
`default_nettype none
package sdram_cfg_pkg;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_LOAD_CFG,
        CMD_READ,
        CMD_WRITE,
        CMD_STOP
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DRAIN,
        ST_SETTLE
    } ctl_state_t;

endpackage : sdram_cfg_pkg
`default_nettype wire

// File: src/sdram_cfg_if.sv
`default_nettype none
interface sdram_cfg_if;
    import sdram_cfg_pkg::*;

    cmd_t        cmd;
    logic [13:0] addr;
    logic        burst_busy;

    modport dev (
        input  cmd,
        input  addr,
        output burst_busy
    );

    modport ctl (
        output cmd,
        output addr,
        input  burst_busy
    );

endinterface : sdram_cfg_if
`default_nettype wire

// File: src/sdram_mode_burst_dev.sv
// Chosen here: the address map and the APB register port.
`include "sdram_cfg_defs.svh"
`default_nettype none
module sdram_mode_burst_dev #(
    parameter int COL_W = 9
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    sdram_cfg_if.dev              bus,
    output logic                  o_col_valid,
    output logic [COL_W-1:0]      o_col_addr,
    output logic                  o_col_write,
    output logic                  o_rd_valid,
    output logic                  o_cfg_loaded,
    output logic                  o_normal_mode,
    output logic [2:0]            o_read_latency
);
    import sdram_cfg_pkg::*;

    // 9 column address bits for the 16-bit organisation, 8 for the 32-bit one
    generate
        if (COL_W != 8 && COL_W != 9) begin : g_bad_col_w
            $error("COL_W must be 8 or 9");
        end
    endgenerate

    logic [`CFG_W-1:0] cfg_r;
    logic              loaded_r;
    logic              active_r;
    logic              write_r;
    logic              ilv_r;
    logic [COL_W-1:0]  base_r;
    logic [COL_W-1:0]  cnt_r;
    logic [COL_W-1:0]  mask_r;
    logic              col_valid_r;
    logic [COL_W-1:0]  col_addr_r;
    logic              col_write_r;
    logic              busy_r;
    logic              rd_p1_r;
    logic              rd_p2_r;
    logic              rd_valid_r;
    logic              normal_r;

    logic [2:0]        span;
    logic [2:0]        lat;
    logic              order_bit;
    logic              wr_single;
    logic              start;
    logic              is_wr;
    logic              stop;
    logic [COL_W-1:0]  mask_new;
    logic              ilv_new;
    logic              rd_nxt;
    logic              active_nxt;

    // offset mask of the aligned block for each span code
    function automatic logic [COL_W-1:0] span_mask(input logic [2:0] code);
        logic [COL_W-1:0] m;
        m = '0;
        case (code)
            `SPAN_2:    m = COL_W'(3'h1); // see [R9]
            `SPAN_4:    m = COL_W'(3'h3); // see [R9]
            `SPAN_8:    m = COL_W'(3'h7); // see [R9]
            `SPAN_FULL: m = '1;           // see [R14]
            default:    m = '0;           // see [R15]
        endcase
        return m;
    endfunction : span_mask

    // block bits stay, only the masked offset moves
    function automatic logic [COL_W-1:0] col_of(
        input logic [COL_W-1:0] base,
        input logic [COL_W-1:0] k,
        input logic [COL_W-1:0] mask,
        input logic             ilv
    );
        logic [COL_W-1:0] off;
        off = '0;
        if (ilv) begin
            off = base ^ k;                         // see [R13]
        end else begin
            off = base + k;                         // see [R12] [R7]
        end
        return (base & ~mask) | (off & mask);       // see [R10] [R21]
    endfunction : col_of

    // mode configuration register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cfg_r    <= `CFG_RESET;
            loaded_r <= 1'b0;
        end else if (bus.cmd == CMD_LOAD_CFG
                     && bus.addr[`SEL_HI:`SEL_LO] == `SEL_PRIMARY) begin // see [R4]
            cfg_r    <= bus.addr;                                       // see [R1]
            loaded_r <= 1'b1;
        end
    end

    always_comb begin
        span      = cfg_r[`SPAN_HI:`SPAN_LO];   // see [R2] [R20]
        order_bit = cfg_r[`ORDER_BIT];          // see [R2]
        lat       = cfg_r[`LAT_HI:`LAT_LO];     // see [R2]
        wr_single = cfg_r[`WR_SINGLE_BIT];      // see [R3]
    end

    // commands before the first load are ignored: the mode would be undefined
    always_comb begin
        is_wr    = (bus.cmd == CMD_WRITE);
        start    = loaded_r && (bus.cmd == CMD_READ || is_wr);
        stop     = (bus.cmd == CMD_STOP);
        mask_new = (is_wr && wr_single) ? '0 : span_mask(span);        // see [R18] [R8]
        ilv_new  = order_bit && span != `SPAN_FULL && span != `SPAN_1; // see [R11] [R6] [R15]
        if (start) begin
            rd_nxt = !is_wr;
        end else if (stop) begin
            rd_nxt = 1'b0;
        end else begin
            rd_nxt = active_r && !write_r;
        end
    end

    always_comb begin
        active_nxt = active_r;
        if (start) begin
            active_nxt = (mask_new != '0);
        end else if (stop) begin
            active_nxt = 1'b0;                                         // see [R7]
        end else if (active_r && mask_r != '1 && cnt_r == mask_r) begin
            active_nxt = 1'b0;                                         // see [R8]
        end
    end

    // column sequencer: the first column leaves on the command's own edge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            active_r    <= 1'b0;
            write_r     <= 1'b0;
            ilv_r       <= 1'b0;
            base_r      <= '0;
            cnt_r       <= '0;
            mask_r      <= '0;
            col_valid_r <= 1'b0;
            col_addr_r  <= '0;
            col_write_r <= 1'b0;
        end else if (start) begin
            active_r    <= active_nxt;
            write_r     <= is_wr;
            ilv_r       <= ilv_new;
            base_r      <= bus.addr[COL_W-1:0];                       // see [R9] [R14]
            cnt_r       <= COL_W'(1'b1);
            mask_r      <= mask_new;
            col_valid_r <= 1'b1;
            col_addr_r  <= bus.addr[COL_W-1:0];                       // see [R15]
            col_write_r <= is_wr;
        end else if (stop) begin
            active_r    <= 1'b0;
            col_valid_r <= 1'b0;
        end else if (active_r) begin
            active_r    <= active_nxt;
            col_valid_r <= 1'b1;                                      // see [R21]
            col_addr_r  <= col_of(base_r, cnt_r, mask_r, ilv_r);
            col_write_r <= write_r;
            cnt_r       <= cnt_r + 1'b1;
        end else begin
            col_valid_r <= 1'b0;
        end
    end

    // busy until the last column of a burst has left
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= active_nxt || (start && !stop);
        end
    end

    // read data strobe delayed by the latency field; codes outside 1..3 act as 3
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_p1_r    <= 1'b0;
            rd_p2_r    <= 1'b0;
            rd_valid_r <= 1'b0;
        end else begin
            rd_p1_r <= rd_nxt;
            rd_p2_r <= rd_p1_r;
            case (lat)
                3'h1:    rd_valid_r <= rd_nxt;   // see [R17] [R20]
                3'h2:    rd_valid_r <= rd_p1_r;  // see [R17]
                default: rd_valid_r <= rd_p2_r;  // see [R17]
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            normal_r <= 1'b0;
        end else begin
            normal_r <= loaded_r && cfg_r[`OP_HI:`OP_LO] == 2'h0
                        && cfg_r[`RSV_HI:`RSV_LO] == 2'h0;            // see [R19] [R3]
        end
    end

    assign bus.burst_busy = busy_r;
    assign o_col_valid    = col_valid_r;
    assign o_col_addr     = col_addr_r;
    assign o_col_write    = col_write_r;
    assign o_rd_valid     = rd_valid_r;
    assign o_cfg_loaded   = loaded_r;
    assign o_normal_mode  = normal_r;
    assign o_read_latency = cfg_r[`LAT_HI:`LAT_LO];

endmodule : sdram_mode_burst_dev
`default_nettype wire

// File: src/sdram_mode_ctl.sv
`include "sdram_cfg_defs.svh"
`default_nettype none
module sdram_mode_ctl #(
    parameter int SETTLE_CYCLES = `LOAD_SETTLE_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    sdram_cfg_if.ctl         bus
);
    import sdram_cfg_pkg::*;

    generate
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
            $error("SETTLE_CYCLES must be 1..255");
        end
    endgenerate

    ctl_state_t           state_r;
    logic [`CFG_W-1:0]    mode_val_r;
    logic [`CFG_W-1:0]    load_val_r;
    logic [31:0]          cmd_reg_r;
    logic [7:0]           settle_r;
    cmd_t                 cmd_r;
    logic [`CFG_W-1:0]    addr_r;
    logic                 refused_r;
    logic                 badmode_r;
    logic                 pready_r;
    logic                 pslverr_r;
    logic [31:0]          prdata_r;

    logic                 wr_acc;
    logic                 cmd_wr;
    logic [2:0]           op;
    logic [`CFG_W-1:0]    clean_val;
    logic                 span_bad;
    logic                 accept;

    always_comb begin
        wr_acc    = i_psel && i_penable && pready_r && i_pwrite;
        cmd_wr    = wr_acc && i_paddr == `REG_CMD;
        op        = i_pwdata[2:0];
        clean_val = mode_val_r;
        clean_val[`RSV_HI:`RSV_LO] = 2'h0;                                // see [R3]
        clean_val[`OP_HI:`OP_LO]   = 2'h0;                                // see [R19]
        clean_val[`SEL_HI:`SEL_LO] = `SEL_PRIMARY;                        // see [R4]
        if (mode_val_r[`SPAN_HI:`SPAN_LO] == `SPAN_FULL) begin
            clean_val[`ORDER_BIT] = 1'b0;                                 // see [R11]
        end
        span_bad  = !(mode_val_r[`SPAN_HI:`SPAN_LO] inside
                      {`SPAN_1, `SPAN_2, `SPAN_4, `SPAN_8, `SPAN_FULL});  // see [R16]
        accept    = cmd_wr && state_r == ST_IDLE && !(op == `OP_LOAD && span_bad);
    end

    // APB: one wait-free access phase, answer prepared in the setup cycle
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= i_psel && !i_penable;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            case (i_paddr)
                `REG_MODE_VAL: prdata_r <= {18'h0_0000, mode_val_r};
                `REG_CMD:      prdata_r <= cmd_reg_r;
                `REG_STATUS: begin
                    prdata_r[`ST_BUSY_BIT]    <= state_r != ST_IDLE;
                    prdata_r[`ST_BURST_BIT]   <= bus.burst_busy;
                    prdata_r[`ST_REFUSED_BIT] <= refused_r;
                    prdata_r[`ST_BADMODE_BIT] <= badmode_r;
                end
                default:       pslverr_r <= i_psel && !i_penable;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode_val_r <= `MODE_VAL_RESET;
            cmd_reg_r  <= 32'h0000_0000;
        end else if (wr_acc && i_paddr == `REG_MODE_VAL) begin
            mode_val_r <= i_pwdata[`CFG_W-1:0];
        end else if (cmd_wr) begin
            cmd_reg_r  <= i_pwdata;
        end
    end

    // sticky flags: a new event wins over a write-one clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            refused_r <= 1'b0;
            badmode_r <= 1'b0;
        end else begin
            if (cmd_wr && state_r != ST_IDLE) begin
                refused_r <= 1'b1;
            end else if (wr_acc && i_paddr == `REG_STATUS && i_pwdata[`ST_REFUSED_BIT]) begin
                refused_r <= 1'b0;
            end
            if (cmd_wr && op == `OP_LOAD && span_bad) begin
                badmode_r <= 1'b1;
            end else if (wr_acc && i_paddr == `REG_STATUS && i_pwdata[`ST_BADMODE_BIT]) begin
                badmode_r <= 1'b0;
            end
        end
    end

    // commands are one-cycle pulses; a load waits for the burst to drain
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r    <= ST_IDLE;
            cmd_r      <= CMD_NOP;
            addr_r     <= '0;
            load_val_r <= '0;
            settle_r   <= 8'h00;
        end else begin
            cmd_r <= CMD_NOP;
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        addr_r <= i_pwdata[`CMD_COL_LO +: `CFG_W];
                        case (op)
                            `OP_LOAD: begin
                                load_val_r <= clean_val;
                                state_r    <= ST_DRAIN;                   // see [R5]
                            end
                            `OP_READ:  cmd_r <= CMD_READ;
                            `OP_WRITE: cmd_r <= CMD_WRITE;
                            `OP_STOP:  cmd_r <= CMD_STOP;                 // see [R7]
                            default:   cmd_r <= CMD_NOP;
                        endcase
                    end
                end
                ST_DRAIN: begin
                    if (!bus.burst_busy && cmd_r == CMD_NOP) begin
                        cmd_r    <= CMD_LOAD_CFG;                         // see [R5]
                        addr_r   <= load_val_r;
                        settle_r <= 8'(SETTLE_CYCLES);
                        state_r  <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    settle_r <= settle_r - 8'h01;
                    if (settle_r == 8'h01) begin
                        state_r <= ST_IDLE;                               // see [R5]
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign bus.cmd   = cmd_r;
    assign bus.addr  = addr_r;
    assign o_prdata  = prdata_r;
    assign o_pready  = pready_r;
    assign o_pslverr = pslverr_r;

endmodule : sdram_mode_ctl
`default_nettype wire

// File: sim/sdram_cfg_properties.sv
`default_nettype none
module sdram_cfg_checker
    import sdram_cfg_pkg::*;
(
    input wire logic                 i_clk,
    input wire logic                 i_sys_rst,
    input wire sdram_cfg_pkg::cmd_t  cmd,
    input wire logic [13:0]          addr,
    input wire logic                 burst_busy
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence load_s;
        cmd == CMD_LOAD_CFG;
    endsequence
    // settle time of the default controller build
    sequence quiet_s;
        (cmd == CMD_NOP) [*2];
    endsequence

    a_load_primary_sel: assert property (load_s |-> addr[13:12] == 2'h0)
        else $error("load aimed at another register");
    a_load_rsv_zero: assert property (load_s |-> addr[11:10] == 2'h0)
        else $error("reserved config bits set on load");
    a_load_normal_op: assert property (load_s |-> addr[8:7] == 2'h0)
        else $error("operating mode bits set on load");
    a_load_when_idle: assert property (load_s |-> !burst_busy)
        else $error("load issued during a burst");
    a_load_then_wait: assert property (load_s |=> quiet_s)
        else $error("command too soon after load");
    a_page_seq_only: assert property ((cmd == CMD_LOAD_CFG && addr[2:0] == 3'h7)
        |-> !addr[3])
        else $error("page span loaded with interleave");
    a_span_code_legal: assert property (load_s |->
        addr[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7})
        else $error("reserved span code loaded");
    a_stop_ends_burst: assert property (cmd == CMD_STOP |=> !burst_busy)
        else $error("burst still busy after stop");
endmodule : sdram_cfg_checker
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sdram_cfg_pkg::*;

    typedef struct {
        logic [13:0] mode;
        logic [2:0]  op;
        logic [8:0]  col;
        int          n;
    } row_t;

    logic        i_clk;
    logic        i_sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        col_valid;
    logic [8:0]  col_addr;
    logic        col_write;
    logic        rd_valid;
    logic        cfg_loaded;
    logic        normal_mode;
    logic [2:0]  read_latency;
    logic [31:0] rdat;
    logic        rerr;
    int          fails;
    int          comparisons;
    int          t;
    // expected column count per row comes from span, write mode and op
    row_t        rows [10] = '{
        '{14'h0018, 3'h2, 9'h1AB, 1}, '{14'h0021, 3'h2, 9'h003, 2},
        '{14'h0022, 3'h2, 9'h005, 4}, '{14'h003A, 3'h2, 9'h00D, 4},
        '{14'h0033, 3'h2, 9'h1F9, 8}, '{14'h002B, 3'h2, 9'h101, 8},
        '{14'h0023, 3'h3, 9'h00E, 8}, '{14'h022B, 3'h3, 9'h006, 1},
        '{14'h0030, 3'h3, 9'h0FF, 1}, '{14'h0212, 3'h2, 9'h002, 4}};

    sdram_cfg_if cfg_bus ();

    sdram_mode_ctl sdram_mode_ctl_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .bus(cfg_bus.ctl));

    sdram_mode_burst_dev #(.COL_W(9)) sdram_mode_burst_dev_i (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .bus(cfg_bus.dev), .o_col_valid(col_valid),
        .o_col_addr(col_addr), .o_col_write(col_write), .o_rd_valid(rd_valid),
        .o_cfg_loaded(cfg_loaded), .o_normal_mode(normal_mode),
        .o_read_latency(read_latency));

    sdram_cfg_checker sdram_cfg_checker_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .cmd(cfg_bus.cmd), .addr(cfg_bus.addr), .burst_busy(cfg_bus.burst_busy));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // starts one edge late so a release never meets the next setup
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) fails++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 20);
        if (n >= 20) fails++;
    endtask : wait_idle

    task automatic load_mode(input logic [13:0] m);
        apb(1'b1, 12'h000, {18'h0, m});
        apb(1'b1, 12'h004, 32'h1);
        wait_idle();
    endtask : load_mode

    task automatic run_burst(input logic [13:0] m, input logic [2:0] op, input logic [8:0] col,
                             input int n, input logic fin);
        int         len;
        int         k;
        logic [8:0] e;
        logic [8:0] msk;
        len = (m[2:0] == 3'h7) ? 512 : (1 << m[2:0]);
        if (op == 3'h3 && m[9]) len = 1;
        msk = 9'(len - 1);
        apb(1'b1, 12'h004, {2'h0, 5'h0, col, 13'h0, op});
        t = 0;
        do begin
            @(posedge i_clk);
            t++;
        end while (col_valid !== 1'b1 && t < 10);
        check("col_lead", t, 32'h0000_0002);
        for (k = 0; k < n; k++) begin
            if (k > 0) @(posedge i_clk);
            e = (m[3] && len > 1 && len < 512) ? (col ^ 9'(k)) : (col + 9'(k));
            e = (col & ~msk) | (e & msk);
            check("col_valid", col_valid, 1'b1);
            check("col_addr", col_addr, e);
            check("col_write", col_write, op == 3'h3);
            check("rd_valid", rd_valid, op == 3'h2 && k >= int'(m[6:4]) - 1);
        end
        if (fin) begin
            @(posedge i_clk);
            check("burst_end", col_valid, 1'b0);
        end
    endtask : run_burst

    initial begin
        fails = 0;
        comparisons = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        i_sys_rst = 1'b1;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        check("mode_val_rst", rdat, 32'h0000_0022);
        apb(1'b0, 12'h008, 32'h0);
        check("status_rst", rdat, 32'h0);
        check("loaded_rst", cfg_loaded, 1'b0);
        check("normal_rst", normal_mode, 1'b0);
        apb(1'b1, 12'h004, 32'h0003_0002);
        repeat (4) begin
            @(posedge i_clk);
            check("no_cfg_burst", col_valid, 1'b0);
        end
        foreach (rows[i]) begin
            load_mode(rows[i].mode);
            check("loaded", cfg_loaded, 1'b1);
            check("latency", read_latency, rows[i].mode[6:4]);
            run_burst(rows[i].mode, rows[i].op, rows[i].col, rows[i].n, 1'b1);
        end
        // interleave asked with page span; controller must clear it
        load_mode(14'h002F);
        run_burst(14'h002F, 3'h2, 9'h1FE, 4, 1'b0);
        apb(1'b1, 12'h004, 32'h4);
        // stop lands one edge after the write, so one more column still shows
        @(posedge i_clk);
        check("page_run", col_valid, 1'b1);
        @(posedge i_clk);
        check("page_stop", col_valid, 1'b0);
        load_mode(14'h0024);
        check("badmode_set", rdat[3], 1'b1);
        check("badmode_keep", read_latency, 3'h2);
        apb(1'b1, 12'h008, 32'h8);
        apb(1'b0, 12'h008, 32'h0);
        check("badmode_clr", rdat, 32'h0);
        apb(1'b1, 12'h000, 32'h3DB3);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        wait_idle();
        check("refused_set", rdat[2], 1'b1);
        check("normal_mode", normal_mode, 1'b1);
        check("primary_load", read_latency, 3'h3);
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped_err", rerr, 1'b1);
        check("unmapped_data", rdat, 32'h0);
        // reset in the middle of a burst drops the burst and the config
        apb(1'b1, 12'h004, 32'h0005_0002);
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        check("rst_col_valid", col_valid, 1'b0);
        check("rst_rd_valid", rd_valid, 1'b0);
        check("rst_loaded", cfg_loaded, 1'b0);
        check("rst_normal", normal_mode, 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        check("rst_mode_val", rdat, 32'h0000_0022);
        print_verdict();
    end

    initial begin
        #200us;
        fails++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
